// ### rtl/sfr_bank_pkg.sv
// Constants, field layouts and carrier types for the timer, capture and PWM register bank.
package sfr_bank_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IDX_W  = 6;

	// Register indices; the APB byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_PC_HOLD        = 6'h03;
	localparam logic [IDX_W-1:0] IDX_CPU_STATUS     = 6'h06;
	localparam logic [IDX_W-1:0] IDX_TBL_LOW        = 6'h0D;
	localparam logic [IDX_W-1:0] IDX_TBL_HIGH       = 6'h0E;
	localparam logic [IDX_W-1:0] IDX_BANK_SEL       = 6'h0F;
	localparam logic [IDX_W-1:0] IDX_TIMER1_COUNT   = 6'h10;
	localparam logic [IDX_W-1:0] IDX_TIMER2_COUNT   = 6'h11;
	localparam logic [IDX_W-1:0] IDX_TIMER3_LOW     = 6'h12;
	localparam logic [IDX_W-1:0] IDX_TIMER3_HIGH    = 6'h13;
	localparam logic [IDX_W-1:0] IDX_TIMER1_PERIOD  = 6'h14;
	localparam logic [IDX_W-1:0] IDX_TIMER2_PERIOD  = 6'h15;
	localparam logic [IDX_W-1:0] IDX_P3C1_LOW       = 6'h16;
	localparam logic [IDX_W-1:0] IDX_P3C1_HIGH      = 6'h17;
	localparam logic [IDX_W-1:0] IDX_PWM1_DUTY_LOW  = 6'h10;
	localparam logic [IDX_W-1:0] IDX_PWM2_DUTY_LOW  = 6'h11;
	localparam logic [IDX_W-1:0] IDX_PWM1_DUTY_HIGH = 6'h12;
	localparam logic [IDX_W-1:0] IDX_PWM2_DUTY_HIGH = 6'h13;
	localparam logic [IDX_W-1:0] IDX_CAPTURE2_LOW   = 6'h14;
	localparam logic [IDX_W-1:0] IDX_CAPTURE2_HIGH  = 6'h15;
	localparam logic [IDX_W-1:0] IDX_TIMER_CFG      = 6'h16;
	localparam logic [IDX_W-1:0] IDX_TIMER_RUN      = 6'h17;
	localparam logic [IDX_W-1:0] IDX_PRODUCT_LOW    = 6'h18;
	localparam logic [IDX_W-1:0] IDX_PRODUCT_HIGH   = 6'h19;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS     = 6'h1A;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK       = 6'h1B;

	localparam logic [3:0] BANK_TIMERS      = 4'h2;
	localparam logic [3:0] BANK_PWM_CAPTURE = 4'h3;

	// Implemented-bit masks of the partly populated registers.
	localparam logic [7:0] PWM1_LOW_MASK   = 8'hC0;
	localparam logic [7:0] PWM2_LOW_MASK   = 8'hE0;
	localparam int unsigned PWM2_TB_BIT    = 5;
	localparam int unsigned WDT_FLAG_BIT   = 4;
	localparam int unsigned SLEEP_FLAG_BIT = 3;

	localparam logic [7:0] BYTE_RESET   = 8'h00;
	localparam logic [3:0] BANK_RESET   = 4'h0;
	localparam logic [3:0] IRQ_RESET    = 4'h0;
	localparam int unsigned IRQ_W       = 4;
	localparam int unsigned IRQ_CAP1    = 0;
	localparam int unsigned IRQ_CAP2    = 1;
	localparam int unsigned IRQ_OVR1    = 2;
	localparam int unsigned IRQ_OVR2    = 3;

	typedef struct packed {
		logic capture2_edge_sel_hi;
		logic capture2_edge_sel_lo;
		logic capture1_edge_sel_hi;
		logic capture1_edge_sel_lo;
		logic timer_pair_join;
		logic timer3_clock_source;
		logic timer2_clock_source;
		logic timer1_clock_source;
	} timer_cfg_t;

	typedef struct packed {
		logic capture2_overrun_flag;
		logic capture1_overrun_flag;
		logic pwm2_output_enable;
		logic pwm1_output_enable;
		logic capture1_period3_select;
		logic timer3_run;
		logic timer2_run;
		logic timer1_run;
	} timer_run_t;

	typedef struct packed {
		logic        load;
		logic        overrun;
		logic [15:0] value;
	} cap_evt_t;

endpackage

// ### rtl/timer_capture_pwm_sfr_bank.sv
// APB register bank holding the timer, capture, PWM duty and multiply product registers.
// Functional notes
// - Unimplemented bits and cells read zero, ignore writes
// - Data zero at power-on and kept through other resets, except the PWM2 time base bit
// - Master clear leaves watchdog and sleep flags
// - Master clear and watchdog load other-reset values
// - Holding register supplies and receives upper counter byte
// - Table pointer bytes clear on every reset; with TBLPTR_LEGACY set, on power-on only
// - Sixteen-bit product bytes at indices 18h, 19h
// - Shared register pair: period3 or capture1 result
// - Timer configuration layout, cleared on other resets
// - Timer run control layout, cleared on every reset
`timescale 1ns/1ns

module timer_capture_pwm_sfr_bank #(
	parameter bit HAS_MULTIPLY    = 1'b1, // Product registers present.
	parameter bit TBLPTR_LEGACY   = 1'b0  // Table pointer keeps its value over other resets.
) (
	input  wire logic                     sys_clk_i,              // Core clock, 100 MHz.
	input  wire logic                     rst_n_i,                // Power-on reset, synchronous.
	input  wire logic                     ext_master_clear_n_i,   // Master clear pin, async.
	input  wire logic                     watchdog_reset_i,       // Watchdog reset, core domain.
	input  wire logic                     sleep_entry_i,          // Core entered sleep, pulse.
	input  wire logic                     psel_i,                 // APB select.
	input  wire logic                     penable_i,              // APB enable.
	input  wire logic                     pwrite_i,               // APB direction.
	input  wire logic [7:0]               paddr_i,                // APB byte address.
	input  wire logic [31:0]              pwdata_i,               // APB write data.
	output logic [31:0]                   prdata_o,               // APB read data.
	output logic                          pready_o,               // APB ready.
	output logic                          pslverr_o,              // APB error, unmapped.
	input  wire sfr_bank_pkg::cap_evt_t   capture1_i,             // Capture1 event.
	input  wire sfr_bank_pkg::cap_evt_t   capture2_i,             // Capture2 event.
	input  wire logic                     product_load_i,         // Multiplier result strobe.
	input  wire logic [15:0]              product_i,              // Multiplier result.
	input  wire logic                     pc_read_i,              // Counter upper byte read strobe.
	input  wire logic [7:0]               pc_upper_i,             // Counter upper byte.
	output logic [7:0]                    pc_upper_holding_o,     // Byte loaded into the counter.
	output logic [15:0]                   table_pointer_o,        // Table pointer.
	output sfr_bank_pkg::timer_cfg_t      timer_config_o,         // Timer configuration.
	output sfr_bank_pkg::timer_run_t      run_control_o,          // Timer run control.
	output logic [7:0]                    timer1_count_o,         // Timer1 count.
	output logic [7:0]                    timer2_count_o,         // Timer2 count.
	output logic [15:0]                   timer3_count_o,         // Timer3 count.
	output logic [7:0]                    timer1_period_o,        // Timer1 period.
	output logic [7:0]                    timer2_period_o,        // Timer2 period.
	output logic [15:0]                   period3_capture1_o,     // Period3 or capture1.
	output logic [9:0]                    pwm1_duty_o,            // PWM1 duty.
	output logic [9:0]                    pwm2_duty_o,            // PWM2 duty.
	output logic                          pwm2_timebase_select_o, // PWM2 time base.
	output logic                          irq_o                   // Interrupt, level.
);

	function automatic logic hit(input logic [5:0] idx, input logic [5:0] target);
		return idx == target;
	endfunction

	logic              external_master_clear_meta_q;
	logic              external_master_clear_sync_q;
	logic              pready_q;
	logic              pslverr_q;
	logic [31:0]       prdata_q;
	logic [3:0]        bank_q;
	logic [7:0]        pc_hold_q;
	logic [7:0]        tbl_low_q;
	logic [7:0]        tbl_high_q;
	logic              wdt_flag_q;
	logic              sleep_flag_q;
	logic [7:0]        timer1_q;
	logic [7:0]        timer2_q;
	logic [15:0]       timer3_q;
	logic [7:0]        period1_q;
	logic [7:0]        period2_q;
	logic [15:0]       p3c1_q;
	logic [7:0]        pwm1_low_q;
	logic [7:0]        pwm2_low_q;
	logic [7:0]        pwm1_high_q;
	logic [7:0]        pwm2_high_q;
	logic [15:0]       capture2_q;
	logic [15:0]       product_q;
	sfr_bank_pkg::timer_cfg_t cfg_q;
	sfr_bank_pkg::timer_run_t run_q;
	sfr_bank_pkg::timer_run_t run_d;
	logic [3:0]        irq_status_q;
	logic [3:0]        irq_status_d;
	logic [3:0]        irq_mask_q;
	logic              irq_q;
	logic [7:0]        rd_byte;
	logic              rd_known;

	// Master clear and watchdog form the other-reset class; the core is idle then.
	wire        other_reset = ~external_master_clear_sync_q | watchdog_reset_i;
	wire [5:0]  idx         = paddr_i[7:2];
	wire [7:0]  wbyte       = pwdata_i[7:0];
	wire        setup       = psel_i & ~penable_i;
	wire        wr_go       = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q & ~other_reset;
	wire        in_b2       = bank_q == sfr_bank_pkg::BANK_TIMERS;
	wire        in_b3       = bank_q == sfr_bank_pkg::BANK_PWM_CAPTURE;
	wire        banked      = idx[5:3] == 3'b010;
	wire        b2_go       = wr_go & in_b2;
	wire        b3_go       = wr_go & in_b3;
	wire        prod_on     = HAS_MULTIPLY;

	wire wr_pc_hold  = wr_go & hit(idx, sfr_bank_pkg::IDX_PC_HOLD);
	wire wr_tbl_low  = wr_go & hit(idx, sfr_bank_pkg::IDX_TBL_LOW);
	wire wr_tbl_high = wr_go & hit(idx, sfr_bank_pkg::IDX_TBL_HIGH);
	wire wr_bank     = wr_go & hit(idx, sfr_bank_pkg::IDX_BANK_SEL);
	wire wr_t1       = b2_go & hit(idx, sfr_bank_pkg::IDX_TIMER1_COUNT);
	wire wr_t2       = b2_go & hit(idx, sfr_bank_pkg::IDX_TIMER2_COUNT);
	wire wr_t3_low   = b2_go & hit(idx, sfr_bank_pkg::IDX_TIMER3_LOW);
	wire wr_t3_high  = b2_go & hit(idx, sfr_bank_pkg::IDX_TIMER3_HIGH);
	wire wr_per1     = b2_go & hit(idx, sfr_bank_pkg::IDX_TIMER1_PERIOD);
	wire wr_per2     = b2_go & hit(idx, sfr_bank_pkg::IDX_TIMER2_PERIOD);
	wire wr_p3_low   = b2_go & hit(idx, sfr_bank_pkg::IDX_P3C1_LOW);
	wire wr_p3_high  = b2_go & hit(idx, sfr_bank_pkg::IDX_P3C1_HIGH);
	wire wr_pw1_low  = b3_go & hit(idx, sfr_bank_pkg::IDX_PWM1_DUTY_LOW);
	wire wr_pw2_low  = b3_go & hit(idx, sfr_bank_pkg::IDX_PWM2_DUTY_LOW);
	wire wr_pw1_high = b3_go & hit(idx, sfr_bank_pkg::IDX_PWM1_DUTY_HIGH);
	wire wr_pw2_high = b3_go & hit(idx, sfr_bank_pkg::IDX_PWM2_DUTY_HIGH);
	wire wr_cfg      = b3_go & hit(idx, sfr_bank_pkg::IDX_TIMER_CFG);
	wire wr_run      = b3_go & hit(idx, sfr_bank_pkg::IDX_TIMER_RUN);
	wire wr_prod_lo  = wr_go & prod_on & hit(idx, sfr_bank_pkg::IDX_PRODUCT_LOW);
	wire wr_prod_hi  = wr_go & prod_on & hit(idx, sfr_bank_pkg::IDX_PRODUCT_HIGH);
	wire wr_irq_stat = wr_go & hit(idx, sfr_bank_pkg::IDX_IRQ_STATUS);
	wire wr_irq_mask = wr_go & hit(idx, sfr_bank_pkg::IDX_IRQ_MASK);

	// Capture1 lands in the shared pair only while it is in capture mode.
	wire cap1_take = capture1_i.load & run_q.capture1_period3_select & ~other_reset;
	wire cap2_take = capture2_i.load & ~other_reset;
	wire ovr1_set  = capture1_i.overrun & ~other_reset;
	wire ovr2_set  = capture2_i.overrun & ~other_reset;

	wire [3:0] irq_events = {ovr2_set, ovr1_set, cap2_take, cap1_take};

	always_comb begin
		rd_known = 1'b1;
		rd_byte  = sfr_bank_pkg::BYTE_RESET;
		if (hit(idx, sfr_bank_pkg::IDX_PC_HOLD)) begin
			rd_byte = pc_hold_q;
		end else if (hit(idx, sfr_bank_pkg::IDX_CPU_STATUS)) begin
			rd_byte[sfr_bank_pkg::WDT_FLAG_BIT]   = wdt_flag_q;
			rd_byte[sfr_bank_pkg::SLEEP_FLAG_BIT] = sleep_flag_q;
		end else if (hit(idx, sfr_bank_pkg::IDX_TBL_LOW)) begin
			rd_byte = tbl_low_q;
		end else if (hit(idx, sfr_bank_pkg::IDX_TBL_HIGH)) begin
			rd_byte = tbl_high_q;
		end else if (hit(idx, sfr_bank_pkg::IDX_BANK_SEL)) begin
			rd_byte = {4'h0, bank_q};
		end else if (banked & in_b2) begin
			if (hit(idx, sfr_bank_pkg::IDX_TIMER1_COUNT)) begin
				rd_byte = timer1_q;
			end else if (hit(idx, sfr_bank_pkg::IDX_TIMER2_COUNT)) begin
				rd_byte = timer2_q;
			end else if (hit(idx, sfr_bank_pkg::IDX_TIMER3_LOW)) begin
				rd_byte = timer3_q[7:0];
			end else if (hit(idx, sfr_bank_pkg::IDX_TIMER3_HIGH)) begin
				rd_byte = timer3_q[15:8];
			end else if (hit(idx, sfr_bank_pkg::IDX_TIMER1_PERIOD)) begin
				rd_byte = period1_q;
			end else if (hit(idx, sfr_bank_pkg::IDX_TIMER2_PERIOD)) begin
				rd_byte = period2_q;
			end else if (hit(idx, sfr_bank_pkg::IDX_P3C1_LOW)) begin
				rd_byte = p3c1_q[7:0];
			end else begin
				rd_byte = p3c1_q[15:8];
			end
		end else if (banked & in_b3) begin
			if (hit(idx, sfr_bank_pkg::IDX_PWM1_DUTY_LOW)) begin
				rd_byte = pwm1_low_q & sfr_bank_pkg::PWM1_LOW_MASK;
			end else if (hit(idx, sfr_bank_pkg::IDX_PWM2_DUTY_LOW)) begin
				rd_byte = pwm2_low_q & sfr_bank_pkg::PWM2_LOW_MASK;
			end else if (hit(idx, sfr_bank_pkg::IDX_PWM1_DUTY_HIGH)) begin
				rd_byte = pwm1_high_q;
			end else if (hit(idx, sfr_bank_pkg::IDX_PWM2_DUTY_HIGH)) begin
				rd_byte = pwm2_high_q;
			end else if (hit(idx, sfr_bank_pkg::IDX_CAPTURE2_LOW)) begin
				rd_byte = capture2_q[7:0];
			end else if (hit(idx, sfr_bank_pkg::IDX_CAPTURE2_HIGH)) begin
				rd_byte = capture2_q[15:8];
			end else if (hit(idx, sfr_bank_pkg::IDX_TIMER_CFG)) begin
				rd_byte = cfg_q;
			end else begin
				rd_byte = run_q;
			end
		end else if (banked) begin
			rd_byte = sfr_bank_pkg::BYTE_RESET;
		end else if (hit(idx, sfr_bank_pkg::IDX_PRODUCT_LOW)) begin
			rd_byte = prod_on ? product_q[7:0] : sfr_bank_pkg::BYTE_RESET;
		end else if (hit(idx, sfr_bank_pkg::IDX_PRODUCT_HIGH)) begin
			rd_byte = prod_on ? product_q[15:8] : sfr_bank_pkg::BYTE_RESET;
		end else if (hit(idx, sfr_bank_pkg::IDX_IRQ_STATUS)) begin
			rd_byte = {4'h0, irq_status_q};
		end else if (hit(idx, sfr_bank_pkg::IDX_IRQ_MASK)) begin
			rd_byte = {4'h0, irq_mask_q};
		end else begin
			rd_known = 1'b0;
		end
	end

	// Hardware overrun flags win over a software write in the same cycle.
	always_comb begin
		run_d = run_q;
		if (wr_run) begin
			run_d = wbyte;
		end
		run_d.capture1_overrun_flag = run_d.capture1_overrun_flag | ovr1_set;
		run_d.capture2_overrun_flag = run_d.capture2_overrun_flag | ovr2_set;
	end

	// Write-one-to-clear status; a new event in the clearing cycle stays set.
	assign irq_status_d = (irq_status_q & ~(wr_irq_stat ? wbyte[3:0] : sfr_bank_pkg::IRQ_RESET)) | irq_events;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			external_master_clear_meta_q <= 1'b1;
			external_master_clear_sync_q <= 1'b1;
		end else begin
			external_master_clear_meta_q <= ext_master_clear_n_i;
			external_master_clear_sync_q <= external_master_clear_meta_q;
		end
	end

	// APB slave: read data is captured in the setup cycle, ready in the access cycle.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~rd_known;
			if (setup) begin
				prdata_q <= {24'h000000, rd_byte};
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			wdt_flag_q   <= 1'b0;
			sleep_flag_q <= 1'b0;
		end else if (watchdog_reset_i) begin
			wdt_flag_q   <= 1'b1;
			sleep_flag_q <= 1'b0;
		end else if (!external_master_clear_sync_q) begin
			wdt_flag_q   <= wdt_flag_q;
			sleep_flag_q <= sleep_flag_q;
		end else if (sleep_entry_i) begin
			sleep_flag_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || other_reset) begin
			bank_q       <= sfr_bank_pkg::BANK_RESET;
			pc_hold_q    <= sfr_bank_pkg::BYTE_RESET;
			cfg_q        <= sfr_bank_pkg::BYTE_RESET;
			run_q        <= sfr_bank_pkg::BYTE_RESET;
			irq_status_q <= sfr_bank_pkg::IRQ_RESET;
			irq_mask_q   <= sfr_bank_pkg::IRQ_RESET;
			irq_q        <= 1'b0;
		end else begin
			bank_q       <= wr_bank ? wbyte[3:0] : bank_q;
			pc_hold_q    <= pc_read_i ? pc_upper_i : (wr_pc_hold ? wbyte : pc_hold_q);
			cfg_q        <= wr_cfg ? wbyte : cfg_q;
			run_q        <= run_d;
			irq_status_q <= irq_status_d;
			irq_mask_q   <= wr_irq_mask ? wbyte[3:0] : irq_mask_q;
			irq_q        <= |(irq_status_d & irq_mask_q);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (TBLPTR_LEGACY ? !rst_n_i : (!rst_n_i || other_reset)) begin
			tbl_low_q  <= sfr_bank_pkg::BYTE_RESET;
			tbl_high_q <= sfr_bank_pkg::BYTE_RESET;
		end else begin
			tbl_low_q  <= wr_tbl_low ? wbyte : tbl_low_q;
			tbl_high_q <= wr_tbl_high ? wbyte : tbl_high_q;
		end
	end

	// Data registers take a defined value at power-on and are untouched by other resets.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			timer1_q  <= sfr_bank_pkg::BYTE_RESET;
			timer2_q  <= sfr_bank_pkg::BYTE_RESET;
			timer3_q  <= {2{sfr_bank_pkg::BYTE_RESET}};
			period1_q <= sfr_bank_pkg::BYTE_RESET;
			period2_q <= sfr_bank_pkg::BYTE_RESET;
		end else begin
			timer1_q  <= wr_t1 ? wbyte : timer1_q;
			timer2_q  <= wr_t2 ? wbyte : timer2_q;
			timer3_q  <= {wr_t3_high ? wbyte : timer3_q[15:8], wr_t3_low ? wbyte : timer3_q[7:0]};
			period1_q <= wr_per1 ? wbyte : period1_q;
			period2_q <= wr_per2 ? wbyte : period2_q;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			p3c1_q     <= {2{sfr_bank_pkg::BYTE_RESET}};
			capture2_q <= {2{sfr_bank_pkg::BYTE_RESET}};
			product_q  <= {2{sfr_bank_pkg::BYTE_RESET}};
		end else begin
			if (cap1_take) begin
				p3c1_q <= capture1_i.value;
			end else begin
				p3c1_q <= {wr_p3_high ? wbyte : p3c1_q[15:8], wr_p3_low ? wbyte : p3c1_q[7:0]};
			end
			capture2_q <= cap2_take ? capture2_i.value : capture2_q;
			if (prod_on && product_load_i && !other_reset) begin
				product_q <= product_i;
			end else begin
				product_q <= {wr_prod_hi ? wbyte : product_q[15:8], wr_prod_lo ? wbyte : product_q[7:0]};
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			pwm1_low_q  <= sfr_bank_pkg::BYTE_RESET;
			pwm2_low_q  <= sfr_bank_pkg::BYTE_RESET;
			pwm1_high_q <= sfr_bank_pkg::BYTE_RESET;
			pwm2_high_q <= sfr_bank_pkg::BYTE_RESET;
		end else begin
			if (other_reset) begin
				pwm2_low_q[sfr_bank_pkg::PWM2_TB_BIT] <= 1'b0;
			end else if (wr_pw2_low) begin
				pwm2_low_q <= wbyte & sfr_bank_pkg::PWM2_LOW_MASK;
			end
			pwm1_low_q  <= wr_pw1_low ? (wbyte & sfr_bank_pkg::PWM1_LOW_MASK) : pwm1_low_q;
			pwm1_high_q <= wr_pw1_high ? wbyte : pwm1_high_q;
			pwm2_high_q <= wr_pw2_high ? wbyte : pwm2_high_q;
		end
	end

	assign prdata_o               = prdata_q;
	assign pready_o               = pready_q;
	assign pslverr_o              = pslverr_q;
	assign pc_upper_holding_o     = pc_hold_q;
	assign table_pointer_o        = {tbl_high_q, tbl_low_q};
	assign timer_config_o         = cfg_q;
	assign run_control_o          = run_q;
	assign timer1_count_o         = timer1_q;
	assign timer2_count_o         = timer2_q;
	assign timer3_count_o         = timer3_q;
	assign timer1_period_o        = period1_q;
	assign timer2_period_o        = period2_q;
	assign period3_capture1_o     = p3c1_q;
	assign pwm1_duty_o            = {pwm1_high_q, pwm1_low_q[7:6]};
	assign pwm2_duty_o            = {pwm2_high_q, pwm2_low_q[7:6]};
	assign pwm2_timebase_select_o = pwm2_low_q[sfr_bank_pkg::PWM2_TB_BIT];
	assign irq_o                  = irq_q;

endmodule

// ### sim/sfr_bank_props.sv
// Concurrent checks on the ports of the timer, capture and PWM register bank.
`timescale 1ns/1ns

module sfr_bank_props (
	input wire logic                     sys_clk_i,            // Core clock.
	input wire logic                     rst_n_i,              // Power-on reset.
	input wire logic                     ext_master_clear_n_i, // Master clear pin.
	input wire logic                     watchdog_reset_i,     // Watchdog reset.
	input wire logic                     psel_i,               // APB select.
	input wire logic                     penable_i,            // APB enable.
	input wire logic [31:0]              prdata_o,             // APB read data.
	input wire logic                     pready_o,             // APB ready.
	input wire logic                     pslverr_o,            // APB error.
	input wire sfr_bank_pkg::cap_evt_t   capture1_i,           // Capture1 event.
	input wire logic                     pc_read_i,            // Upper byte strobe.
	input wire logic [7:0]               pc_upper_i,           // Upper byte.
	input wire logic [7:0]               pc_upper_holding_o,   // Holding register.
	input wire logic [15:0]              table_pointer_o,      // Table pointer.
	input wire sfr_bank_pkg::timer_cfg_t timer_config_o,       // Timer configuration.
	input wire sfr_bank_pkg::timer_run_t run_control_o,        // Run control.
	input wire logic [7:0]               timer1_count_o,       // Timer1 count.
	input wire logic [15:0]              period3_capture1_o,   // Shared pair.
	input wire logic [9:0]               pwm1_duty_o           // PWM1 duty.
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	// The pin history keeps hardware-load checks away from a master clear still in the synchroniser.
	logic [3:0] mc_hist_q;
	wire        quiet = (&mc_hist_q) && ext_master_clear_n_i && !watchdog_reset_i;
	always_ff @(posedge sys_clk_i) begin
		mc_hist_q <= {mc_hist_q[2:0], ext_master_clear_n_i};
	end

	sequence wdt_hit;
		watchdog_reset_i;
	endsequence
	sequence mc_held;
		!ext_master_clear_n_i [*4];
	endsequence

	a_rdata_upper_zero: assert property (prdata_o[31:8] == 24'h000000) else $error("upper read bits set");
	a_ready_one_pulse: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o) else $error("ready timing");
	a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
	a_wdt_clears_ctrl: assert property (wdt_hit |=> timer_config_o == 8'h00 && run_control_o == 8'h00)
		else $error("control kept over watchdog");
	a_wdt_keeps_data: assert property (wdt_hit |=> $stable(timer1_count_o) && $stable(pwm1_duty_o))
		else $error("data lost over watchdog");
	a_table_ptr_clear: assert property (wdt_hit |=> table_pointer_o == 16'h0000) else $error("table pointer kept");
	a_mc_clears_ctrl: assert property (mc_held |=> timer_config_o == 8'h00 && $stable(timer1_count_o))
		else $error("master clear values");
	a_pc_take_upper: assert property (pc_read_i && quiet |=> pc_upper_holding_o == $past(pc_upper_i))
		else $error("holding not loaded");
	a_cap1_shared: assert property (capture1_i.load && run_control_o.capture1_period3_select && quiet
		|=> period3_capture1_o == $past(capture1_i.value)) else $error("capture1 not in pair");
	a_overrun_flag: assert property (capture1_i.overrun && quiet |=> run_control_o.capture1_overrun_flag)
		else $error("overrun flag not set");
endmodule

bind timer_capture_pwm_sfr_bank sfr_bank_props sfr_bank_props_i (.sys_clk_i, .rst_n_i, .ext_master_clear_n_i,
	.watchdog_reset_i, .psel_i, .penable_i, .prdata_o, .pready_o, .pslverr_o, .capture1_i, .pc_read_i, .pc_upper_i,
	.pc_upper_holding_o, .table_pointer_o, .timer_config_o, .run_control_o, .timer1_count_o, .period3_capture1_o,
	.pwm1_duty_o);

// ### sim/timer_capture_pwm_sfr_bank_tb.sv
// Self-checking testbench for the timer, capture and PWM register bank.
`timescale 1ns/1ns

module timer_capture_pwm_sfr_bank_tb;
	logic sys_clk_i = 1'b0, rst_n_i = 1'b0, ext_master_clear_n_i = 1'b1, watchdog_reset_i = 1'b0;
	logic sleep_entry_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, product_load_i = 1'b0;
	logic pc_read_i = 1'b0, pready_o, pslverr_o, pwm2_timebase_select_o, irq_o, err_seen;
	logic [7:0] paddr_i = 8'h00, pc_upper_i = 8'h00, pc_upper_holding_o, timer1_count_o, timer2_count_o;
	logic [7:0] timer1_period_o, timer2_period_o;
	logic [31:0] pwdata_i = 32'h00000000, prdata_o, rd;
	logic [15:0] product_i = 16'h0000, table_pointer_o, timer3_count_o, period3_capture1_o;
	logic [9:0] pwm1_duty_o, pwm2_duty_o;
	sfr_bank_pkg::cap_evt_t capture1_i = '0, capture2_i = '0;
	sfr_bank_pkg::timer_cfg_t timer_config_o;
	sfr_bank_pkg::timer_run_t run_control_o;
	int errors = 0, total_checks = 0;

	timer_capture_pwm_sfr_bank timer_capture_pwm_sfr_bank_i (.sys_clk_i, .rst_n_i, .ext_master_clear_n_i,
		.watchdog_reset_i, .sleep_entry_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .capture1_i, .capture2_i, .product_load_i, .product_i, .pc_read_i, .pc_upper_i,
		.pc_upper_holding_o, .table_pointer_o, .timer_config_o, .run_control_o, .timer1_count_o, .timer2_count_o,
		.timer3_count_o, .timer1_period_o, .timer2_period_o, .period3_capture1_o, .pwm1_duty_o, .pwm2_duty_o,
		.pwm2_timebase_select_o, .irq_o);

	always #5 sys_clk_i = ~sys_clk_i;

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	// One APB transfer; the request stands until ready is sampled high.
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
		int n = 0;
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= {24'h000000, d};
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50) errors++;
		rd = prdata_o;
		err_seen = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp, input string msg);
		apb(1'b0, idx, 8'h00);
		check(rd, {24'h000000, exp}, msg);
	endtask
	task automatic cap1(input logic ovr, input logic [15:0] v);
		@(posedge sys_clk_i);
		capture1_i <= '{load: 1'b1, overrun: ovr, value: v};
		@(posedge sys_clk_i);
		capture1_i <= '0;
	endtask

	task automatic t_reset;
		check(timer_config_o, 8'h00, "config after power-on");
		check(run_control_o, 8'h00, "run after power-on");
		check(table_pointer_o, 16'h0000, "tblptr por");
		apb(1'b1, 6'h0F, 8'h03);
		rdchk(6'h16, 8'h00, "config read");
		rdchk(6'h3F, 8'h00, "unmapped read");
		check(err_seen, 1'b1, "unmapped error");
		$display("test reset done");
	endtask
	task automatic t_bits;
		apb(1'b1, 6'h10, 8'hFF);
		rdchk(6'h10, 8'hC0, "pwm1 low bits");
		apb(1'b1, 6'h12, 8'hA5);
		apb(1'b1, 6'h11, 8'hFF);
		rdchk(6'h11, 8'hE0, "pwm2 low bits");
		check(pwm1_duty_o, 10'h297, "pwm1 duty");
		check(pwm2_duty_o, 10'h003, "pwm2 duty");
		check(pwm2_timebase_select_o, 1'b1, "pwm2 time base");
		apb(1'b1, 6'h14, 8'h5A);
		rdchk(6'h14, 8'h00, "capture2 read only");
		apb(1'b1, 6'h16, 8'h9C);
		tick(1);
		check(timer_config_o, 8'h9C, "config layout");
		$display("test bits done");
	endtask
	task automatic t_shared;
		apb(1'b1, 6'h17, 8'h08);
		cap1(1'b1, 16'hBEEF);
		rdchk(6'h17, 8'h48, "overrun flag");
		apb(1'b1, 6'h0F, 8'h02);
		rdchk(6'h16, 8'hEF, "capture1 low");
		rdchk(6'h17, 8'hBE, "capture1 high");
		apb(1'b1, 6'h16, 8'h34);
		apb(1'b1, 6'h17, 8'h12);
		tick(1);
		check(period3_capture1_o, 16'h1234, "period3 pair");
		@(posedge sys_clk_i);
		product_i <= 16'hC3A7;
		product_load_i <= 1'b1;
		@(posedge sys_clk_i);
		product_load_i <= 1'b0;
		rdchk(6'h18, 8'hA7, "product low");
		rdchk(6'h19, 8'hC3, "product high");
		$display("test shared done");
	endtask
	task automatic t_pc_irq;
		@(posedge sys_clk_i);
		pc_upper_i <= 8'h6D;
		pc_read_i <= 1'b1;
		@(posedge sys_clk_i);
		pc_read_i <= 1'b0;
		rdchk(6'h03, 8'h6D, "holding from counter");
		apb(1'b1, 6'h03, 8'h21);
		tick(1);
		check(pc_upper_holding_o, 8'h21, "holding to counter");
		apb(1'b1, 6'h1B, 8'h02);
		@(posedge sys_clk_i);
		capture2_i <= '{load: 1'b1, overrun: 1'b0, value: 16'h1357};
		@(posedge sys_clk_i);
		capture2_i <= '0;
		tick(2);
		check(irq_o, 1'b1, "irq raised");
		apb(1'b1, 6'h1B, 8'h00);
		tick(2);
		check(irq_o, 1'b0, "irq masked");
		apb(1'b1, 6'h1B, 8'h02);
		apb(1'b1, 6'h1A, 8'h02);
		tick(2);
		check(irq_o, 1'b0, "irq cleared");
		rdchk(6'h1A, 8'h05, "status cleared");
		$display("test pc irq done");
	endtask
	task automatic t_other_resets;
		apb(1'b1, 6'h10, 8'h77);
		apb(1'b1, 6'h0D, 8'h5C);
		@(posedge sys_clk_i);
		watchdog_reset_i <= 1'b1;
		tick(2);
		watchdog_reset_i <= 1'b0;
		tick(1);
		check(timer_config_o, 8'h00, "config after watchdog");
		check(run_control_o, 8'h00, "run after watchdog");
		check(table_pointer_o, 16'h0000, "tblptr wdt");
		check(timer1_count_o, 8'h77, "count kept");
		check(pwm1_duty_o, 10'h297, "duty kept");
		rdchk(6'h06, 8'h10, "watchdog flag");
		@(posedge sys_clk_i);
		sleep_entry_i <= 1'b1;
		@(posedge sys_clk_i);
		sleep_entry_i <= 1'b0;
		apb(1'b1, 6'h0F, 8'h03);
		apb(1'b1, 6'h16, 8'h55);
		@(posedge sys_clk_i);
		ext_master_clear_n_i <= 1'b0;
		tick(6);
		ext_master_clear_n_i <= 1'b1;
		tick(4);
		rdchk(6'h06, 8'h18, "flags kept");
		check(timer_config_o, 8'h00, "config after master clear");
		check(timer1_count_o, 8'h77, "count kept");
		$display("test other resets done");
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		errors++;
		close_out();
	end

	initial begin
		tick(12);
		rst_n_i <= 1'b1;
		t_reset();
		t_bits();
		t_shared();
		t_pc_irq();
		t_other_resets();
		close_out();
	end
endmodule
